//--- pirq_params.svh
// Constants for the peripheral interrupt flag registers: offsets, fields, reset values.
//
// Contract
// - Flags set on events, regardless of enables.
// - First register: gate, adc, rx, tx, ssp, ccp1, tmr2, tmr1.
// - Receive and transmit flags are read-only.
// - All flags clear to zero on reset.
// - One means pending, zero means not pending.
// - Second register: oscfail, cmp2, cmp1, eeprom, collision, ccp2.
// - Second register bits 2 and 1 read zero.
// - Peripheral enable gates every flag to core.
`ifndef PIRQ_PARAMS_SVH
`define PIRQ_PARAMS_SVH

// Byte offsets of the registers on the register bus.
`define PIRQ_OFF_FLAGS_ONE     32'h0000_0000
`define PIRQ_OFF_FLAGS_TWO     32'h0000_0004
`define PIRQ_OFF_MASK_ONE      32'h0000_0008
`define PIRQ_OFF_MASK_TWO      32'h0000_000C
`define PIRQ_OFF_CONTROL       32'h0000_0010

// Bit positions in the first flag register.
`define PIRQ_BIT_TIMER1_GATE   7
`define PIRQ_BIT_ADC_DONE      6
`define PIRQ_BIT_SERIAL_RX     5
`define PIRQ_BIT_SERIAL_TX     4
`define PIRQ_BIT_SYNC_SERIAL   3
`define PIRQ_BIT_CAPCOMP1      2
`define PIRQ_BIT_TIMER2_MATCH  1
`define PIRQ_BIT_TIMER1_OVF    0

// Bit positions in the second flag register.
`define PIRQ_BIT_OSC_FAIL      7
`define PIRQ_BIT_COMPARATOR2   6
`define PIRQ_BIT_COMPARATOR1   5
`define PIRQ_BIT_EEPROM_DONE   4
`define PIRQ_BIT_BUS_COLLISION 3
`define PIRQ_BIT_CAPCOMP2      0

// Bit position of the peripheral interrupt enable in the control register.
`define PIRQ_BIT_PERIPH_EN     0

// Implemented and software-writable bits of each flag register.
`define PIRQ_IMPL_ONE          8'hFF
`define PIRQ_SWWR_ONE          8'hCF
`define PIRQ_IMPL_TWO          8'hF9
`define PIRQ_SWWR_TWO          8'hF9

// Reset values.
`define PIRQ_RST_FLAGS         8'h00
`define PIRQ_RST_MASK          8'h00
`define PIRQ_RST_CONTROL       1'b0

// Bus response codes.
`define PIRQ_RESP_OKAY         2'h0
`define PIRQ_RESP_SLVERR       2'h2

`endif

//--- pirq_pkg.sv
// Types shared by the peripheral interrupt flag register files.
package pirq_pkg;

  // One flag register byte.
  typedef logic [7:0] flag_byte_t;

  // Register selected by a bus address.
  typedef enum logic [2:0] {
    SEL_FLAGS_ONE,
    SEL_FLAGS_TWO,
    SEL_MASK_ONE,
    SEL_MASK_TWO,
    SEL_CONTROL,
    SEL_NONE
  } reg_sel_e;

  // Write channel state.
  typedef enum logic {
    WR_IDLE,
    WR_RESP
  } wr_state_e;

  // Read channel state.
  typedef enum logic {
    RD_IDLE,
    RD_RESP
  } rd_state_e;

endpackage

//--- flag_bank.sv
// One byte of sticky event flags with a software write port.
`timescale 1ns/100ps
`default_nettype none
`include "pirq_params.svh"

module flag_bank
#(
  parameter pirq_pkg::flag_byte_t IMPL_MASK = `PIRQ_IMPL_ONE,
  parameter pirq_pkg::flag_byte_t SW_MASK   = `PIRQ_SWWR_ONE
)
(
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire pirq_pkg::flag_byte_t set_evt,
  input  wire logic               wr_en,
  input  wire pirq_pkg::flag_byte_t wr_data,
  output pirq_pkg::flag_byte_t    flags
);
  import pirq_pkg::*;

  flag_byte_t flags_reg;   // Stored flags.
  flag_byte_t flags_next;  // Next value of the stored flags.

  // Software replaces only its writable bits, then events are ORed on top,
  // so an event in the same cycle as a clearing write survives.
  always_comb
  begin
    flags_next = flags_reg;
    if (wr_en)
    begin
      // Read-only and unimplemented bits keep their value here.
      flags_next = (flags_reg & ~SW_MASK) | (wr_data & SW_MASK);
    end
    // Events set their flag whatever any enable says.
    flags_next = (flags_next | set_evt) & IMPL_MASK;
  end

  // Register the flags; reset clears every one.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      flags_reg <= `PIRQ_RST_FLAGS;
    end
    else
    begin
      flags_reg <= flags_next;
    end
  end

  assign flags = flags_reg;

endmodule
`default_nettype wire

//--- peripheral_irq_flag_regs.sv
// Peripheral interrupt flag registers behind an AXI4-Lite slave, with masks and one interrupt line.
//
// The register addresses and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "pirq_params.svh"

module peripheral_irq_flag_regs
#(
  parameter int ADDR_W = 8
)
(
  input  wire logic              CORE_CLK,
  input  wire logic              RST_N,
  // Write address channel.
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic [2:0]        S_AXI_AWPROT,
  input  wire logic              S_AXI_AWVALID,
  output logic                   S_AXI_AWREADY,
  // Write data channel.
  input  wire logic [31:0]       S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  input  wire logic              S_AXI_WVALID,
  output logic                   S_AXI_WREADY,
  // Write response channel.
  output logic [1:0]             S_AXI_BRESP,
  output logic                   S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  // Read address channel.
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic [2:0]        S_AXI_ARPROT,
  input  wire logic              S_AXI_ARVALID,
  output logic                   S_AXI_ARREADY,
  // Read data channel.
  output logic [31:0]            S_AXI_RDATA,
  output logic [1:0]             S_AXI_RRESP,
  output logic                   S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY,
  // Event inputs for the first flag register, high for each cycle of the condition.
  input  wire logic              TIMER1_GATE_EVT,
  input  wire logic              ADC_DONE_EVT,
  input  wire logic              SERIAL_RECEIVE_EVT,
  input  wire logic              SERIAL_TRANSMIT_EVT,
  input  wire logic              SYNC_SERIAL_EVT,
  input  wire logic              CAPCOMP1_EVT,
  input  wire logic              TIMER2_MATCH_EVT,
  input  wire logic              TIMER1_OVERFLOW_EVT,
  // Event inputs for the second flag register.
  input  wire logic              OSC_FAIL_EVT,
  input  wire logic              COMPARATOR2_EVT,
  input  wire logic              COMPARATOR1_EVT,
  input  wire logic              EEPROM_WRITE_DONE_EVT,
  input  wire logic              BUS_COLLISION_EVT,
  input  wire logic              CAPCOMP2_EVT,
  // Level interrupt request towards the core.
  output logic                   IRQ
);
  import pirq_pkg::*;

  // Map a bus address onto one of the registers, or none when unmapped.
  function automatic reg_sel_e decode_addr(input logic [ADDR_W-1:0] addr);
    logic [31:0] wide;
    wide = 32'(addr);
    unique case (wide)
      `PIRQ_OFF_FLAGS_ONE: decode_addr = SEL_FLAGS_ONE;
      `PIRQ_OFF_FLAGS_TWO: decode_addr = SEL_FLAGS_TWO;
      `PIRQ_OFF_MASK_ONE:  decode_addr = SEL_MASK_ONE;
      `PIRQ_OFF_MASK_TWO:  decode_addr = SEL_MASK_TWO;
      `PIRQ_OFF_CONTROL:   decode_addr = SEL_CONTROL;
      default:             decode_addr = SEL_NONE;
    endcase
  endfunction

  // Flag register contents as seen by software.
  flag_byte_t        flags_one;         // First flag register.
  flag_byte_t        flags_two;         // Second flag register.
  flag_byte_t        set_one;           // Event vector of the first register.
  flag_byte_t        set_two;           // Event vector of the second register.

  // Mask and control registers.
  flag_byte_t        mask_one_reg;      // Interrupt mask for the first register.
  flag_byte_t        mask_one_next;     // Next mask for the first register.
  flag_byte_t        mask_two_reg;      // Interrupt mask for the second register.
  flag_byte_t        mask_two_next;     // Next mask for the second register.
  logic              periph_en_reg;     // Peripheral interrupt enable.
  logic              periph_en_next;    // Next peripheral interrupt enable.

  // Write channel state.
  wr_state_e         wr_state_reg;      // Write state.
  wr_state_e         wr_state_next;     // Next write state.
  logic              aw_held_reg;       // Write address captured.
  logic              aw_held_next;      // Next write address captured flag.
  logic [ADDR_W-1:0] aw_addr_reg;       // Captured write address.
  logic [ADDR_W-1:0] aw_addr_next;      // Next captured write address.
  logic              w_held_reg;        // Write data captured.
  logic              w_held_next;       // Next write data captured flag.
  logic [7:0]        w_data_reg;        // Captured low data byte.
  logic [7:0]        w_data_next;       // Next captured data byte.
  logic              w_lane_reg;        // Captured strobe of the low byte.
  logic              w_lane_next;       // Next captured strobe.
  logic [1:0]        bresp_reg;         // Write response code.
  logic [1:0]        bresp_next;        // Next write response code.
  logic              wr_do;             // Write is carried out in this cycle.
  reg_sel_e          wr_sel;            // Register addressed by the write.
  logic              wr_byte;           // Write carries the low byte.

  // Read channel state.
  rd_state_e         rd_state_reg;      // Read state.
  rd_state_e         rd_state_next;     // Next read state.
  logic [31:0]       rdata_reg;         // Read data held for the master.
  logic [31:0]       rdata_next;        // Next read data.
  logic [1:0]        rresp_reg;         // Read response code.
  logic [1:0]        rresp_next;        // Next read response code.
  reg_sel_e          rd_sel;            // Register addressed by the read.

  // Gather the first register's events in their documented bit order.
  always_comb
  begin
    set_one = 8'h00;
    set_one[`PIRQ_BIT_TIMER1_GATE]  = TIMER1_GATE_EVT;
    set_one[`PIRQ_BIT_ADC_DONE]     = ADC_DONE_EVT;
    set_one[`PIRQ_BIT_SERIAL_RX]    = SERIAL_RECEIVE_EVT;
    set_one[`PIRQ_BIT_SERIAL_TX]    = SERIAL_TRANSMIT_EVT;
    set_one[`PIRQ_BIT_SYNC_SERIAL]  = SYNC_SERIAL_EVT;
    set_one[`PIRQ_BIT_CAPCOMP1]     = CAPCOMP1_EVT;
    set_one[`PIRQ_BIT_TIMER2_MATCH] = TIMER2_MATCH_EVT;
    set_one[`PIRQ_BIT_TIMER1_OVF]   = TIMER1_OVERFLOW_EVT;
  end

  // Gather the second register's events; bits 2 and 1 have no source.
  always_comb
  begin
    set_two = 8'h00;
    set_two[`PIRQ_BIT_OSC_FAIL]      = OSC_FAIL_EVT;
    set_two[`PIRQ_BIT_COMPARATOR2]   = COMPARATOR2_EVT;
    set_two[`PIRQ_BIT_COMPARATOR1]   = COMPARATOR1_EVT;
    set_two[`PIRQ_BIT_EEPROM_DONE]   = EEPROM_WRITE_DONE_EVT;
    set_two[`PIRQ_BIT_BUS_COLLISION] = BUS_COLLISION_EVT;
    set_two[`PIRQ_BIT_CAPCOMP2]      = CAPCOMP2_EVT;
  end

  // Decode of the captured write address.
  assign wr_sel  = decode_addr(aw_addr_reg);
  assign wr_byte = wr_do && w_lane_reg;

  // First flag register; receive and transmit bits are not writable.
  flag_bank
  #(
    .IMPL_MASK (`PIRQ_IMPL_ONE),
    .SW_MASK   (`PIRQ_SWWR_ONE)
  )
  u_flags_one
  (
    .clk     (CORE_CLK),
    .rst_n   (RST_N),
    .set_evt (set_one),
    .wr_en   (wr_byte && (wr_sel == SEL_FLAGS_ONE)),
    .wr_data (w_data_reg),
    .flags   (flags_one)
  );

  // Second flag register; its two unimplemented bits stay at zero.
  flag_bank
  #(
    .IMPL_MASK (`PIRQ_IMPL_TWO),
    .SW_MASK   (`PIRQ_SWWR_TWO)
  )
  u_flags_two
  (
    .clk     (CORE_CLK),
    .rst_n   (RST_N),
    .set_evt (set_two),
    .wr_en   (wr_byte && (wr_sel == SEL_FLAGS_TWO)),
    .wr_data (w_data_reg),
    .flags   (flags_two)
  );

  // Next values of the mask and control registers on a write.
  always_comb
  begin
    mask_one_next  = mask_one_reg;
    mask_two_next  = mask_two_reg;
    periph_en_next = periph_en_reg;
    if (wr_byte)
    begin
      unique case (wr_sel)
        SEL_MASK_ONE:
        begin
          mask_one_next = w_data_reg;
        end
        SEL_MASK_TWO:
        begin
          mask_two_next = w_data_reg & `PIRQ_IMPL_TWO;
        end
        SEL_CONTROL:
        begin
          periph_en_next = w_data_reg[`PIRQ_BIT_PERIPH_EN];
        end
        default:
        begin
          // Flag registers are written inside their banks; unmapped writes do nothing.
        end
      endcase
    end
  end

  // Register masks and control; reset leaves every source masked.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      mask_one_reg  <= `PIRQ_RST_MASK;
      mask_two_reg  <= `PIRQ_RST_MASK;
      periph_en_reg <= `PIRQ_RST_CONTROL;
    end
    else
    begin
      mask_one_reg  <= mask_one_next;
      mask_two_reg  <= mask_two_next;
      periph_en_reg <= periph_en_next;
    end
  end

  // A set flag counts as pending; nothing reaches the core without the peripheral enable.
  assign IRQ = periph_en_reg && (|((flags_one & mask_one_reg) | (flags_two & mask_two_reg)));

  // Write channel: take address and data in either order, then answer once both are in.
  always_comb
  begin
    wr_state_next = wr_state_reg;
    aw_held_next  = aw_held_reg;
    aw_addr_next  = aw_addr_reg;
    w_held_next   = w_held_reg;
    w_data_next   = w_data_reg;
    w_lane_next   = w_lane_reg;
    bresp_next    = bresp_reg;
    wr_do         = 1'b0;
    unique case (wr_state_reg)
      WR_IDLE:
      begin
        // Capture the address when offered.
        if (S_AXI_AWVALID && S_AXI_AWREADY)
        begin
          aw_held_next = 1'b1;
          aw_addr_next = S_AXI_AWADDR;
        end
        // Capture the data when offered; only the low byte is stored.
        if (S_AXI_WVALID && S_AXI_WREADY)
        begin
          w_held_next = 1'b1;
          w_data_next = S_AXI_WDATA[7:0];
          w_lane_next = S_AXI_WSTRB[0];
        end
        // Both halves present: carry the write out and answer.
        if (aw_held_reg && w_held_reg)
        begin
          wr_do         = 1'b1;
          aw_held_next  = 1'b0;
          w_held_next   = 1'b0;
          wr_state_next = WR_RESP;
          bresp_next    = (wr_sel == SEL_NONE) ? `PIRQ_RESP_SLVERR : `PIRQ_RESP_OKAY;
        end
      end
      WR_RESP:
      begin
        // Hold the response until the master takes it.
        if (S_AXI_BREADY)
        begin
          wr_state_next = WR_IDLE;
        end
      end
    endcase
  end

  // Register the write channel state.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      wr_state_reg <= WR_IDLE;
      aw_held_reg  <= 1'b0;
      aw_addr_reg  <= '0;
      w_held_reg   <= 1'b0;
      w_data_reg   <= 8'h00;
      w_lane_reg   <= 1'b0;
      bresp_reg    <= `PIRQ_RESP_OKAY;
    end
    else
    begin
      wr_state_reg <= wr_state_next;
      aw_held_reg  <= aw_held_next;
      aw_addr_reg  <= aw_addr_next;
      w_held_reg   <= w_held_next;
      w_data_reg   <= w_data_next;
      w_lane_reg   <= w_lane_next;
      bresp_reg    <= bresp_next;
    end
  end

  // Each half is accepted once per write and only while no response is open.
  assign S_AXI_AWREADY = (wr_state_reg == WR_IDLE) && !aw_held_reg;
  assign S_AXI_WREADY  = (wr_state_reg == WR_IDLE) && !w_held_reg;
  assign S_AXI_BVALID  = (wr_state_reg == WR_RESP);
  assign S_AXI_BRESP   = bresp_reg;

  // Decode of the offered read address.
  assign rd_sel = decode_addr(S_AXI_ARADDR);

  // Read channel: sample the addressed register when the address is taken.
  always_comb
  begin
    rd_state_next = rd_state_reg;
    rdata_next    = rdata_reg;
    rresp_next    = rresp_reg;
    unique case (rd_state_reg)
      RD_IDLE:
      begin
        if (S_AXI_ARVALID)
        begin
          rd_state_next = RD_RESP;
          rresp_next    = `PIRQ_RESP_OKAY;
          // Upper bits and unmapped addresses read as zero.
          unique case (rd_sel)
            SEL_FLAGS_ONE: rdata_next = {24'h000000, flags_one};
            SEL_FLAGS_TWO: rdata_next = {24'h000000, flags_two};
            SEL_MASK_ONE:  rdata_next = {24'h000000, mask_one_reg};
            SEL_MASK_TWO:  rdata_next = {24'h000000, mask_two_reg};
            SEL_CONTROL:   rdata_next = {31'h00000000, periph_en_reg};
            default:
            begin
              rdata_next = 32'h00000000;
              rresp_next = `PIRQ_RESP_SLVERR;
            end
          endcase
        end
      end
      RD_RESP:
      begin
        // Hold the data until the master takes it.
        if (S_AXI_RREADY)
        begin
          rd_state_next = RD_IDLE;
        end
      end
    endcase
  end

  // Register the read channel state.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      rd_state_reg <= RD_IDLE;
      rdata_reg    <= 32'h00000000;
      rresp_reg    <= `PIRQ_RESP_OKAY;
    end
    else
    begin
      rd_state_reg <= rd_state_next;
      rdata_reg    <= rdata_next;
      rresp_reg    <= rresp_next;
    end
  end

  // Read handshake outputs.
  assign S_AXI_ARREADY = (rd_state_reg == RD_IDLE);
  assign S_AXI_RVALID  = (rd_state_reg == RD_RESP);
  assign S_AXI_RDATA   = rdata_reg;
  assign S_AXI_RRESP   = rresp_reg;

endmodule
`default_nettype wire

//--- pirq_event_source.sv
// Model of the peripheral event sources that pulse the flag inputs on command.
`timescale 1ns/100ps
`default_nettype none
module pirq_event_source
(
  input  wire logic        clk,
  input  wire logic [13:0] cmd,
  output logic      [13:0] evt
);
  logic [13:0] evt_next; // Next event levels, one cycle after the command.

  // Each commanded bit becomes a condition one cycle later, lasting as long as the command, whatever any enable holds.
  always_comb
  begin
    evt_next = cmd;
  end

  // The event lines change only right after a rising edge.
  always_ff @(posedge clk)
  begin
    evt <= evt_next;
  end
endmodule
`default_nettype wire

//--- pirq_assertions.sv
// Checker of bus answers, read values and the interrupt line at the block's ports.
`timescale 1ns/100ps
`default_nettype none
module pirq_assertions
#(
  parameter int ADDR_W = 8
)
(
  input wire logic              CORE_CLK,
  input wire logic              RST_N,
  input wire logic              S_AXI_AWVALID,
  input wire logic              S_AXI_AWREADY,
  input wire logic              S_AXI_WVALID,
  input wire logic              S_AXI_WREADY,
  input wire logic [1:0]        S_AXI_BRESP,
  input wire logic              S_AXI_BVALID,
  input wire logic              S_AXI_BREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic              S_AXI_ARVALID,
  input wire logic              S_AXI_ARREADY,
  input wire logic [31:0]       S_AXI_RDATA,
  input wire logic [1:0]        S_AXI_RRESP,
  input wire logic              S_AXI_RVALID,
  input wire logic              S_AXI_RREADY,
  input wire logic              IRQ
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  // Address and data of one write taken at the same edge.
  sequence s_wr_taken;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence

  // The response comes out at the register update edge, one cycle after the handshake edge.
  sequence s_wr_answer;
    !S_AXI_BVALID ##1 S_AXI_BVALID;
  endsequence

  a_write_answer: assert property (s_wr_taken |=> s_wr_answer)
    else $error("write response late or early");
  a_resp_holds: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped before taken");
  a_write_blocks: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write accepted while response pending");
  a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read data not returned next cycle");
  a_read_holds: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data changed before taken");
  a_read_blocks: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read accepted while data pending");
  a_upper_zero: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  a_gap_bits: assert property (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == 'h4 |=> S_AXI_RDATA[2:1] == 2'h0)
    else $error("unimplemented bits read nonzero");
  a_unmapped_read: assert property (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR >= 'h14
    |=> S_AXI_RRESP == 2'h2 && S_AXI_RDATA == 32'h00000000)
    else $error("unmapped read not refused");
  a_reset_clear: assert property (disable iff (1'b0) !RST_N |=> !IRQ && !S_AXI_BVALID && !S_AXI_RVALID)
    else $error("state not cleared by reset");
endmodule

bind peripheral_irq_flag_regs pirq_assertions #(.ADDR_W(ADDR_W)) u_pirq_assertions (
  .CORE_CLK(CORE_CLK), .RST_N(RST_N), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
  .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .IRQ(IRQ));
`default_nettype wire

//--- peripheral_irq_flag_regs_test.sv
// Self-checking bench for the peripheral interrupt flag registers over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module peripheral_irq_flag_regs_test;
  logic        clk = 1'b0;      // Core clock, 200 MHz.
  logic        rst_n = 1'b0;    // Synchronous reset, active low.
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  wire logic   awready, wready, bvalid, arready, rvalid, irq;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  logic [13:0] cmd = 14'h0000;  // Commands to the event source model.
  wire logic [13:0] evt;        // Event lines: [7:0] first register, [13:8] second.
  logic [7:0]  exp1, exp2;      // Expected flag bytes.
  int          error_cnt = 0;
  int          checks = 0;

  // Clock with a 5 ns period.
  always #2.5 clk = ~clk;

  peripheral_irq_flag_regs #(.ADDR_W(8)) u_peripheral_irq_flag_regs (
    .CORE_CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .TIMER1_GATE_EVT(evt[7]), .ADC_DONE_EVT(evt[6]), .SERIAL_RECEIVE_EVT(evt[5]),
    .SERIAL_TRANSMIT_EVT(evt[4]), .SYNC_SERIAL_EVT(evt[3]), .CAPCOMP1_EVT(evt[2]),
    .TIMER2_MATCH_EVT(evt[1]), .TIMER1_OVERFLOW_EVT(evt[0]), .OSC_FAIL_EVT(evt[13]),
    .COMPARATOR2_EVT(evt[12]), .COMPARATOR1_EVT(evt[11]), .EEPROM_WRITE_DONE_EVT(evt[10]),
    .BUS_COLLISION_EVT(evt[9]), .CAPCOMP2_EVT(evt[8]), .IRQ(irq));

  pirq_event_source u_pirq_event_source (.clk(clk), .cmd(cmd), .evt(evt));

  // Compares a seen value with the expected one and reports a mismatch.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic close_out();
    if (error_cnt == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // One write: address and data offered together, each released when taken.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit aw_p, w_p, done;
    aw_p = 1;
    w_p = 1;
    done = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 100; n++)
    begin
      @(posedge clk);
      if (aw_p && awready === 1'b1)
      begin
        aw_p = 0;
        awvalid <= 1'b0;
      end
      if (w_p && wready === 1'b1)
      begin
        w_p = 0;
        wvalid <= 1'b0;
      end
      if (!aw_p && !w_p && bvalid === 1'b1)
      begin
        done = 1;
        break;
      end
    end
    // A response that never came counts as a mismatch.
    check({31'h0, done}, 32'h1);
    check({30'h0, bresp}, {30'h0, er});
    bready <= 1'b0;
  endtask

  // One read, compared with the expected data and response.
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    bit a_p, done;
    a_p = 1;
    done = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 100; n++)
    begin
      @(posedge clk);
      if (a_p && arready === 1'b1)
      begin
        a_p = 0;
        arvalid <= 1'b0;
      end
      else if (!a_p && rvalid === 1'b1)
      begin
        done = 1;
        break;
      end
    end
    // Read data that never came counts as a mismatch.
    check({31'h0, done}, 32'h1);
    check(rdata, ed);
    check({30'h0, rresp}, {30'h0, er});
    rready <= 1'b0;
  endtask

  // Commands a one-cycle event on line i and lets the flag land.
  task automatic pulse(input int i);
    @(posedge clk);
    cmd <= 14'h0001 << i;
    @(posedge clk);
    cmd <= 14'h0000;
    repeat (2) @(posedge clk);
  endtask

  // Watchdog that cuts a hang short.
  initial
  begin
    #100000;
    error_cnt++;
    close_out();
  end

  // Main sequence of tests.
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a <= 16; a += 4)
      axi_rd(8'(a), 32'h0, 2'h0);
    axi_rd(8'h14, 32'h0, 2'h2);
    axi_wr(8'h00, 32'hFF, 2'h0);
    axi_rd(8'h00, 32'hCF, 2'h0);
    axi_wr(8'h04, 32'hFF, 2'h0);
    axi_rd(8'h04, 32'hF9, 2'h0);
    axi_wr(8'h14, 32'hFF, 2'h2);
    axi_wr(8'h00, 32'h00, 2'h0);
    axi_wr(8'h04, 32'h00, 2'h0);
    axi_rd(8'h04, 32'h00, 2'h0);
    // Each event line sets only its own bit, with every mask and enable off.
    exp1 = 8'h00;
    exp2 = 8'h00;
    for (int i = 0; i < 14; i++)
    begin
      pulse(i);
      if (i < 8)
        exp1[i] = 1'b1;
      else
        exp2[(i == 8) ? 0 : i - 6] = 1'b1;
      axi_rd(8'h00, {24'h0, exp1}, 2'h0);
      axi_rd(8'h04, {24'h0, exp2}, 2'h0);
    end
    check({31'h0, irq}, 32'h0);
    // Receive and transmit flags survive a clearing write.
    axi_wr(8'h00, 32'h00, 2'h0);
    axi_wr(8'h04, 32'h00, 2'h0);
    axi_rd(8'h00, 32'h30, 2'h0);
    axi_rd(8'h04, 32'h00, 2'h0);
    // The interrupt line needs mask and peripheral enable both.
    axi_wr(8'h08, 32'h01, 2'h0);
    pulse(0);
    check({31'h0, irq}, 32'h0);
    axi_wr(8'h10, 32'h01, 2'h0);
    check({31'h0, irq}, 32'h1);
    axi_wr(8'h00, 32'h00, 2'h0);
    check({31'h0, irq}, 32'h0);
    // An event on the very edge of a clearing write keeps the flag.
    fork
      axi_wr(8'h00, 32'h00, 2'h0);
      begin
        @(posedge clk);
        cmd <= 14'h0001;
        @(posedge clk);
        cmd <= 14'h0000;
      end
    join
    axi_rd(8'h00, 32'h31, 2'h0);
    check({31'h0, irq}, 32'h1);
    // The second mask drives the line as well; its unused bits stay zero.
    axi_wr(8'h08, 32'h00, 2'h0);
    axi_wr(8'h0C, 32'hFF, 2'h0);
    axi_rd(8'h0C, 32'hF9, 2'h0);
    check({31'h0, irq}, 32'h0);
    pulse(8);
    check({31'h0, irq}, 32'h1);
    // A reset in mid-run clears every flag, mask and enable.
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    axi_rd(8'h00, 32'h00, 2'h0);
    axi_rd(8'h04, 32'h00, 2'h0);
    axi_rd(8'h0C, 32'h00, 2'h0);
    axi_rd(8'h08, 32'h00, 2'h0);
    axi_rd(8'h10, 32'h00, 2'h0);
    check({31'h0, irq}, 32'h0);
    close_out();
  end
endmodule
`default_nettype wire
